// >>> pkg/mecs_pkg.sv
/*
 * Constants for the motion engine control/status block: register
 * offsets, field positions, codes, reset values and engine tuning.
 * Assumes byte-wide registers on a 12-bit register address.
 */
package mecs_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned SAMPLE_W = 12;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_ENGINE_ON_OFF = 12'h100;
    localparam logic [11:0] OFF_SENSITIVITY = 12'h101;
    localparam logic [11:0] OFF_DETECT_SC = 12'h102;
    localparam logic [11:0] OFF_TICK_SCAN = 12'h103;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SC0_EXT_HI = 7;
    localparam int SC0_EXT_LO = 6;
    localparam int SC0_DISABLED = 5;
    localparam int SC0_PAUSE = 4;
    localparam int SC0_DIRMODE = 3;
    localparam int SC0_DIR = 2;
    localparam int SC0_MOTION = 1;
    localparam int SC0_SETTLED = 0;
    localparam int SC1_TICK = 7;
    localparam int SC1_FREQ_HI = 6;
    localparam int SC1_FREQ_LO = 3;
    localparam int SC1_SCAN = 2;
    localparam int SC1_RSVD = 1;
    localparam int SC1_DUAL = 0;

    // ----------------------------------------------------------------
    // Codes and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ENGINE_ON_CODE = 8'h11;
    localparam logic [7:0] ENGINE_OFF_CODE = 8'h00;
    localparam logic [7:0] SENS_ADVISED_MAX = 8'h3F;
    localparam logic [7:0] ON_OFF_RST = 8'h00;
    localparam logic [1:0] EXT_RST = 2'h0;
    localparam logic [3:0] FREQ_RST = 4'h0;

    // ----------------------------------------------------------------
    // Engine tuning
    // ----------------------------------------------------------------
    localparam logic [11:0] SETTLE_BAND = 12'h020;
    localparam logic [7:0] SETTLE_EVENTS = 8'h40;
    localparam logic [12:0] THRESHOLD_FLOOR = 13'h010;
    localparam int OFFSET_FRAC = 4;

    typedef enum logic {MECS_OFF, MECS_RUN} mecs_state_e;

endpackage

// >>> pkg/mecs_det_if.sv
/*
 * Carrier between the register core and the detector.
 * Assumes both ends share ref_clk; step is a one-cycle event.
 */
`timescale 1ns/1ps
interface mecs_det_if;
    import mecs_pkg::*;
    logic step;
    logic detect;
    logic restart;
    logic [SAMPLE_W-1:0] sample;
    logic [7:0] sens;
    logic [1:0] extLevel;
    logic [2:0] range;
    logic motion;
    logic positive;
    logic settled;

    modport core (output step, detect, restart, sample, sens, extLevel,
                  range, input motion, positive, settled);
    modport det (input step, detect, restart, sample, sens, extLevel,
                 range, output motion, positive, settled);
endinterface

// >>> rtl/mecs_detector.sv
/*
 * Motion detector: tracks the sensor DC offset, decides when it has
 * settled and flags samples that leave the offset by more than the
 * threshold. Assumes step pulses once per conversion.
 */
`timescale 1ns/1ps
module mecs_detector
    import mecs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    mecs_det_if.det det
);

    logic signed [15:0] offsetAcc_reg;
    logic [7:0] settleCnt_reg;
    logic settled_reg;
    logic signed [12:0] dev;
    logic [11:0] mag;
    logic [12:0] threshold;
    logic [7:0] rangeTerm;

    // ----------------------------------------------------------------
    // Deviation and threshold
    // ----------------------------------------------------------------
    assign dev = $signed({det.sample[SAMPLE_W-1], det.sample})
        - $signed(offsetAcc_reg[15:OFFSET_FRAC]);
    assign mag = dev[12] ? 12'((-dev)) : dev[11:0];
    // RULE5: range weakened
    // Each extended level halves what range control adds.
    assign rangeTerm = {det.range, 5'h00} >> det.extLevel;
    // RULE1: sensitivity threshold
    // RULE2: larger means shorter
    assign threshold = {3'h0, det.sens, 2'h0} + {5'h00, rangeTerm}
        + THRESHOLD_FLOOR;
    // RULE15: unsettled gives no motion
    assign det.motion = det.step && det.detect && settled_reg
        && ({1'b0, mag} > threshold);
    assign det.positive = !dev[12];
    assign det.settled = settled_reg;

    // ----------------------------------------------------------------
    // Offset tracking
    // ----------------------------------------------------------------
    // Tracking runs while paused so recovery needs no resettling.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || det.restart)
        begin
            offsetAcc_reg <= 16'sh0000;
        end
        else if (det.step)
        begin
            offsetAcc_reg <= offsetAcc_reg + 16'(dev);
        end
    end

    // ----------------------------------------------------------------
    // Settling
    // ----------------------------------------------------------------
    // RULE15: offset settle detect
    // RULE16: restart clears settled
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || det.restart)
        begin
            settleCnt_reg <= 8'h00;
            settled_reg <= 1'b0;
        end
        else if (det.step && !settled_reg)
        begin
            if (mag >= SETTLE_BAND)
            begin
                settleCnt_reg <= 8'h00;
            end
            else if (settleCnt_reg == SETTLE_EVENTS - 8'h01)
            begin
                settled_reg <= 1'b1;
            end
            else
            begin
                settleCnt_reg <= settleCnt_reg + 8'h01;
            end
        end
    end

    a_restart_unsettles: assert property (@(posedge ref_clk)
        disable iff (!rst_n) det.restart |=> !settled_reg) // RULE16
        else $error("settled survived a restart");
    a_motion_needs_settle: assert property (@(posedge ref_clk) // RULE15
        disable iff (!rst_n) det.motion
        |-> settleCnt_reg == SETTLE_EVENTS - 8'h01 && det.detect)
        else $error("motion reported while unsettled or paused");

endmodule

// >>> rtl/mecs_core.sv
/*
 * Control and status registers of the motion engine, with the
 * engine sequencing that updates them once per conversion event.
 * Assumes a byte register port and one conversion pulse per sample;
 * all inputs are synchronous to ref_clk.
 */
// How it works
// RULE1: Sensitivity is 8-bit read/write; zero most sensitive, all ones least.
// RULE2: Bigger sensitivity value shortens detection range, smaller lengthens it.
// RULE3: Software should keep sensitivity at or below 3Fh for useful detection.
// RULE4: Bits 7-6 of status/control 0 pick four extended levels.
// RULE5: Higher extended level weakens the range control effect.
// RULE6: Enable code at an event clears the disabled bit 5.
// RULE7: Disable code sets disabled bit at next event, then processing stops.
// RULE8: Software lets one conversion event pass after writing disable code.
// RULE9: Pause bit 4 stops detection; events and sample capture continue.
// RULE10: Clearing pause resumes detection at the next conversion event.
// RULE11: Bit 3 selects direction mode; off makes direction bit invalid.
// RULE12: Direction bit 2 loads when motion flag sets, held until cleared.
// RULE13: Engine sets motion flag bit 1; only software clears it. Here re-enabling at an event also clears it, together with direction bit 2.
// RULE14: Software polls the motion flag and clears it.
// RULE15: Settled bit 0 set once offset stable; until then motion invalid.
// RULE16: Settled restarts from zero after reset, re-enable and wake.
// RULE17: Software sets tick bit 7 each second; engine consumes and clears.
// RULE18: Tick/scan register holds tick, frequency, scan, dual, zero bit.
// RULE19: On/off register takes any byte, reads back last written.
// RULE20: Status updates and control sampling happen only at events; wakeFromSleep clears settled bit 0 in any cycle.
// RULE21: Read-only and reserved bits ignore writes; reserved reads zero.
`timescale 1ns/1ps
module mecs_core
    import mecs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [DATA_W-1:0] regWrData,
    output logic [DATA_W-1:0] regRdData,
    input wire logic convEvent,
    input wire logic [SAMPLE_W-1:0] convSample,
    input wire logic wakeFromSleep,
    input wire logic [2:0] rangeControl,
    output logic engineRunning,
    output logic secondTick,
    output logic [SAMPLE_W-1:0] lastSample
);

    mecs_det_if detBus ();

    mecs_state_e state_reg;
    logic [7:0] onOff_reg;
    logic [7:0] sens_reg;
    logic [1:0] ext_reg;
    logic pause_reg;
    logic dirMode_reg;
    logic disabled_reg;
    logic dir_reg;
    logic motion_reg;
    logic settled_reg;
    logic tick_reg;
    logic [3:0] freq_reg;
    logic scan_reg;
    logic dual_reg;
    logic pauseActive_reg;
    logic dirModeActive_reg;
    logic wrOnOff;
    logic wrSens;
    logic wrSc0;
    logic wrSc1;
    logic engineOn;
    logic enabling;
    logic motionClear;
    logic [7:0] sc0View;
    logic [7:0] sc1View;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign wrOnOff = regWrEn && (regAddr == OFF_ENGINE_ON_OFF);
    assign wrSens = regWrEn && (regAddr == OFF_SENSITIVITY);
    assign wrSc0 = regWrEn && (regAddr == OFF_DETECT_SC);
    assign wrSc1 = regWrEn && (regAddr == OFF_TICK_SCAN);
    assign engineOn = state_reg == MECS_RUN;
    assign enabling = convEvent && !engineOn
        && (onOff_reg == ENGINE_ON_CODE);
    // RULE13: software clear only
    assign motionClear = wrSc0 && !regWrData[SC0_MOTION];

    // ----------------------------------------------------------------
    // Software-owned fields
    // ----------------------------------------------------------------
    // RULE19: any byte stored
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            onOff_reg <= ON_OFF_RST;
        end
        else if (wrOnOff)
        begin
            onOff_reg <= regWrData;
        end
    end

    // RULE1: no reset value
    // Sensitivity is left unreset; software must load it first.
    always_ff @(posedge ref_clk)
    begin
        if (wrSens)
        begin
            sens_reg <= regWrData;
        end
    end

    // RULE4: extended level field
    // RULE21: status bits not writable
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ext_reg <= EXT_RST;
            pause_reg <= 1'b0;
            dirMode_reg <= 1'b0;
        end
        else if (wrSc0)
        begin
            ext_reg <= regWrData[SC0_EXT_HI:SC0_EXT_LO];
            pause_reg <= regWrData[SC0_PAUSE];
            dirMode_reg <= regWrData[SC0_DIRMODE];
        end
    end

    // RULE18: tick and scan fields
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            freq_reg <= FREQ_RST;
            scan_reg <= 1'b0;
            dual_reg <= 1'b0;
        end
        else if (wrSc1)
        begin
            freq_reg <= regWrData[SC1_FREQ_HI:SC1_FREQ_LO];
            scan_reg <= regWrData[SC1_SCAN];
            dual_reg <= regWrData[SC1_DUAL];
        end
    end

    // ----------------------------------------------------------------
    // Tick
    // ----------------------------------------------------------------
    // RULE17: engine consumes tick
    // A set landing on the consuming event wins, so no second is lost.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tick_reg <= 1'b0;
            secondTick <= 1'b0;
        end
        else
        begin
            secondTick <= convEvent && engineOn && tick_reg;
            if (wrSc1 && regWrData[SC1_TICK])
            begin
                tick_reg <= 1'b1;
            end
            else if (convEvent && engineOn)
            begin
                tick_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Engine sequencing
    // ----------------------------------------------------------------
    // RULE20: only at events
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= MECS_OFF;
            disabled_reg <= 1'b1;
        end
        else if (convEvent)
        begin
            unique case (state_reg)
                MECS_OFF:
                begin
                    // RULE6: enable acknowledge
                    if (onOff_reg == ENGINE_ON_CODE)
                    begin
                        state_reg <= MECS_RUN;
                        disabled_reg <= 1'b0;
                    end
                end
                MECS_RUN:
                begin
                    // RULE7: disable acknowledge
                    if (onOff_reg == ENGINE_OFF_CODE)
                    begin
                        state_reg <= MECS_OFF;
                        disabled_reg <= 1'b1;
                    end
                end
            endcase
        end
    end
    assign engineRunning = engineOn;

    // RULE9: pause sampled
    // RULE10: resume at event
    // RULE11: mode sampled
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pauseActive_reg <= 1'b0;
            dirModeActive_reg <= 1'b0;
        end
        else if (convEvent)
        begin
            pauseActive_reg <= pause_reg;
            dirModeActive_reg <= dirMode_reg;
        end
    end

    // RULE9: samples kept
    // Captured during pause too, so restart needs no fresh fill.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lastSample <= '0;
        end
        else if (convEvent && engineOn)
        begin
            lastSample <= convSample;
        end
    end

    // ----------------------------------------------------------------
    // Detector link
    // ----------------------------------------------------------------
    assign detBus.step = convEvent && engineOn;
    // RULE9: detection gated
    assign detBus.detect = !pauseActive_reg;
    // RULE16: re-enable and wake
    assign detBus.restart = enabling || wakeFromSleep;
    assign detBus.sample = convSample;
    assign detBus.sens = sens_reg;
    assign detBus.extLevel = ext_reg;
    assign detBus.range = rangeControl;

    mecs_detector u_detector (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .det(detBus)
    );

    // ----------------------------------------------------------------
    // Engine-owned status
    // ----------------------------------------------------------------
    // RULE13: set wins over clear
    // RULE12: direction latch
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || enabling)
        begin
            motion_reg <= 1'b0;
            dir_reg <= 1'b0;
        end
        else if (detBus.motion)
        begin
            motion_reg <= 1'b1;
            if (!motion_reg && dirModeActive_reg)
            begin
                dir_reg <= detBus.positive;
            end
        end
        else if (motionClear)
        begin
            motion_reg <= 1'b0;
        end
    end

    // RULE15: settled mirrored
    // RULE16: cleared on restart
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || detBus.restart)
        begin
            settled_reg <= 1'b0;
        end
        else if (convEvent && engineOn)
        begin
            settled_reg <= detBus.settled;
        end
    end

    // ----------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------
    assign sc0View = {ext_reg, disabled_reg, pause_reg, dirMode_reg,
                      dir_reg, motion_reg, settled_reg};
    // RULE21: reserved reads zero
    assign sc1View = {tick_reg, freq_reg, scan_reg, 1'b0, dual_reg};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            regRdData <= 8'h00;
        end
        else if (regRdEn)
        begin
            unique case (regAddr)
                OFF_ENGINE_ON_OFF: regRdData <= onOff_reg;
                OFF_SENSITIVITY: regRdData <= sens_reg;
                OFF_DETECT_SC: regRdData <= sc0View;
                OFF_TICK_SCAN: regRdData <= sc1View;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Off code already stored when the event samples it
    sequence s_offStored;
        onOff_reg == ENGINE_OFF_CODE;
    endsequence
    sequence s_eventWhileRun;
        convEvent && engineOn && !wrOnOff;
    endsequence

    a_disable_ack: assert property (@(posedge ref_clk) // RULE7
        disable iff (!rst_n) s_offStored ##0 s_eventWhileRun
        |=> disabled_reg && !engineOn)
        else $error("disable code not acknowledged at event");
    a_enable_ack: assert property (@(posedge ref_clk) // RULE6
        disable iff (!rst_n) enabling |=> !disabled_reg && !settled_reg)
        else $error("enable code not acknowledged");
    a_status_between: assert property (@(posedge ref_clk) // RULE20
        disable iff (!rst_n) !convEvent |=> $stable(disabled_reg))
        else $error("disabled bit moved between events");
    a_motion_sticky: assert property (@(posedge ref_clk) // RULE13
        disable iff (!rst_n) motion_reg && !motionClear && !enabling
        |=> motion_reg)
        else $error("motion flag dropped without software clear");
    a_dir_held: assert property (@(posedge ref_clk) // RULE12
        disable iff (!rst_n) motion_reg && !enabling |=> $stable(dir_reg))
        else $error("direction changed while motion flag held");
    a_tick_consumed: assert property (@(posedge ref_clk) // RULE17
        disable iff (!rst_n) convEvent && engineOn && tick_reg && !wrSc1
        |=> !tick_reg ##1 !secondTick)
        else $error("tick not consumed exactly once");
    a_rsvd_zero: assert property (@(posedge ref_clk) // RULE21
        disable iff (!rst_n) regRdEn && regAddr == OFF_TICK_SCAN
        |=> regRdData[SC1_RSVD] == 1'b0)
        else $error("reserved bit read as one");
    a_onoff_readback: assert property (@(posedge ref_clk) // RULE19
        disable iff (!rst_n) wrOnOff ##1 !wrOnOff ##1 (regRdEn && !regWrEn
        && regAddr == OFF_ENGINE_ON_OFF) |=> regRdData == $past(regWrData, 3))
        else $error("on/off register read back wrong value");
    a_pause_blocks: assert property (@(posedge ref_clk) // RULE9
        disable iff (!rst_n) pauseActive_reg && !motion_reg |=> !motion_reg)
        else $error("motion detected while paused");

endmodule

// >>> bench/mecs_host_model.sv
/*
 * Host application model: drives the byte register port of the
 * motion engine and notes each expected read value in a queue.
 * Assumes every task is entered just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
module mecs_host_model
    import mecs_pkg::*;
(
    input wire logic ref_clk,
    output logic [ADDR_W-1:0] regAddr,
    output logic regWrEn,
    output logic regRdEn,
    output logic [DATA_W-1:0] regWrData
);
    logic [7:0] expQ[$];
    logic [7:0] mskQ[$];

    initial
    begin
        regAddr = '0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = '0;
    end

    // ----------------------------------------------------------------
    // Register cycles
    // ----------------------------------------------------------------
    // Two edges each, so a strobe never rises twice in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e,
        input logic [7:0] m);
        expQ.push_back(e);
        mskQ.push_back(m);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(posedge ref_clk);
    endtask

    // ----------------------------------------------------------------
    // Application habits
    // ----------------------------------------------------------------
    // advised ceiling kept
    task automatic setSens(input logic [7:0] s);
        wr(OFF_SENSITIVITY, (s > SENS_ADVISED_MAX) ? SENS_ADVISED_MAX : s);
    endtask

    task automatic clearMotion(input logic [7:0] keep);
        wr(OFF_DETECT_SC, keep & 8'hFD);
    endtask

    task automatic setTick(input logic [7:0] rest);
        wr(OFF_TICK_SCAN, rest | 8'h80);
    endtask
endmodule

// >>> bench/motion_engine_control_status_bench.sv
/*
 * Self-checking bench of the motion engine registers: drives
 * conversion events, checks reads through a queue of expectations.
 * Assumes mecs_core is the top and mecs_host_model the host side.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module motion_engine_control_status_bench
    import mecs_pkg::*;
;
    logic ref_clk, rst_n, regWrEn, regRdEn, convEvent, wakeFromSleep;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData;
    logic [SAMPLE_W-1:0] convSample, lastSample;
    logic [2:0] rangeControl;
    logic engineRunning, secondTick, rdSeen;
    logic [7:0] e, m, rs;
    int n_tests, mismatches, cycles, ticks;
    logic [7:0] tSens [4] = '{8'h3F, 8'h00, 8'h00, 8'h00};
    logic [2:0] tRng [4] = '{3'h0, 3'h0, 3'h7, 3'h7};
    logic [1:0] tExt [4] = '{2'h0, 2'h0, 2'h0, 2'h3};
    logic [11:0] tSmp [4] = '{12'h0C8, 12'h0C8, 12'hF9C, 12'hF9C};
    logic tMot [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic tDir [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

    mecs_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
        .regRdData(regRdData), .convEvent(convEvent),
        .convSample(convSample), .wakeFromSleep(wakeFromSleep),
        .rangeControl(rangeControl), .engineRunning(engineRunning),
        .secondTick(secondTick), .lastSample(lastSample));

    mecs_host_model i_host (.ref_clk(ref_clk), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Monitor and timeout
    // ----------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        rdSeen <= regRdEn;
        cycles++;
        if (secondTick === 1'b1)
            ticks++;
        if (rdSeen === 1'b1 && i_host.expQ.size() > 0)
        begin
            e = i_host.expQ.pop_front();
            m = i_host.mskQ.pop_front();
            `CHK(regRdData & m, e & m);
        end
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Small noise keeps the sample path honest
    task automatic ev(input int n, input logic [11:0] s);
        repeat (n)
        begin
            convEvent <= 1'b1;
            convSample <= s + 12'($urandom % 4);
            @(posedge ref_clk);
        end
        convEvent <= 1'b0;
        @(posedge ref_clk);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        convEvent = 1'b0;
        convSample = '0;
        wakeFromSleep = 1'b0;
        rangeControl = 3'h0;
        rdSeen = 1'b0;
        n_tests = 0;
        mismatches = 0;
        cycles = 0;
        ticks = 0;
        void'($urandom(5827));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        i_host.rd(OFF_ENGINE_ON_OFF, 8'h00, 8'hFF);
        i_host.rd(OFF_DETECT_SC, 8'h20, 8'hFF);
        i_host.rd(OFF_TICK_SCAN, 8'h00, 8'hFF);
        i_host.rd(12'h1FF, 8'h00, 8'hFF);
        i_host.wr(OFF_ENGINE_ON_OFF, ENGINE_ON_CODE);
        ev(1, 12'h000);
        `CHK(engineRunning, 1'b1);
        i_host.rd(OFF_DETECT_SC, 8'h00, 8'h20);
        rs = 8'($urandom % 64);
        i_host.setSens(rs);
        i_host.rd(OFF_SENSITIVITY, rs, 8'hFF);
        i_host.setTick(8'h7D);
        i_host.rd(OFF_TICK_SCAN, 8'hFD, 8'hFF);
        ev(4, 12'h000);
        `CHK(ticks, 1);
        i_host.rd(OFF_TICK_SCAN, 8'h7D, 8'hFF);
        i_host.wr(OFF_TICK_SCAN, 8'h00);
        i_host.wr(OFF_DETECT_SC, 8'hFF);
        i_host.rd(OFF_DETECT_SC, 8'hD8, 8'hFA);
        i_host.setSens(8'h00);
        i_host.wr(OFF_DETECT_SC, 8'h08);
        ev(150, 12'h000);
        i_host.rd(OFF_DETECT_SC, 8'h09, 8'hFF);
        // Threshold table: sensitivity, range and extended level
        for (int i = 0; i < 4; i++)
        begin
            i_host.setSens(tSens[i]);
            i_host.wr(OFF_DETECT_SC, {tExt[i], 6'h08});
            rangeControl <= tRng[i];
            ev(150, 12'h000);
            ev(1, tSmp[i]);
            ev(3, 12'h000);
            i_host.rd(OFF_DETECT_SC, {tExt[i], 3'h1, tDir[i], tMot[i], 1'b0},
                tMot[i] ? 8'hFE : 8'hFA);
        end
        rangeControl <= 3'h0;
        i_host.wr(OFF_DETECT_SC, 8'h18);
        ev(150, 12'h000);
        ev(1, 12'h200);
        `CHK(lastSample[11:4], 8'h20);
        ev(3, 12'h000);
        i_host.rd(OFF_DETECT_SC, 8'h10, 8'h12);
        i_host.wr(OFF_DETECT_SC, 8'h08);
        ev(150, 12'h000);
        ev(1, 12'h200);
        i_host.rd(OFF_DETECT_SC, 8'h02, 8'h02);
        wakeFromSleep <= 1'b1;
        @(posedge ref_clk);
        wakeFromSleep <= 1'b0;
        ev(1, 12'h000);
        i_host.rd(OFF_DETECT_SC, 8'h00, 8'h01);
        i_host.clearMotion(8'h08);
        i_host.wr(OFF_ENGINE_ON_OFF, ENGINE_OFF_CODE);
        `CHK(engineRunning, 1'b1);
        i_host.rd(OFF_DETECT_SC, 8'h00, 8'h20);
        // one event lets the engine see the off code
        ev(1, 12'h000);
        `CHK(engineRunning, 1'b0);
        ev(1, 12'h200);
        i_host.rd(OFF_DETECT_SC, 8'h20, 8'h22);
        i_host.wr(OFF_ENGINE_ON_OFF, 8'h55);
        i_host.rd(OFF_ENGINE_ON_OFF, 8'h55, 8'hFF);
        ev(1, 12'h000);
        `CHK(engineRunning, 1'b0);
        i_host.wr(OFF_ENGINE_ON_OFF, ENGINE_ON_CODE);
        ev(1, 12'h000);
        i_host.rd(OFF_DETECT_SC, 8'h00, 8'h23);
        repeat (2) @(posedge ref_clk);
        end_sim();
    end
endmodule
